/* rtl/cigf_pkg.sv */
// Package for the fast pulse counter input glitch filter
package cigf_pkg;
	localparam int unsigned CIGF_CNT_W    = 16;
	localparam int unsigned CIGF_DIV_W    = 16;
	localparam logic [CIGF_CNT_W-1:0] CIGF_CNT_ZERO = 16'h0000;
	localparam logic [CIGF_CNT_W-1:0] CIGF_CNT_ONE  = 16'h0001;
	localparam logic [CIGF_DIV_W-1:0] CIGF_DIV_ZERO = 16'h0000;
	localparam logic [CIGF_DIV_W-1:0] CIGF_DIV_ONE  = 16'h0001;
	localparam logic                  CIGF_LVL_RST  = 1'b0;

	typedef struct packed {
		logic                  enable;
		logic [CIGF_DIV_W-1:0] div;
		logic [CIGF_CNT_W-1:0] samples;
	} cigf_cfg_t;
endpackage : cigf_pkg

/* rtl/cigf_filter.sv */
// Glitch filter between a fast counter input pin and its accumulator
//
// Overview of operation
// - Enabled filter uses divider and sample count
// - Sample input on each filter tick
// - Count ticks, clear counter at target
// - Stable level at target goes to accumulator
// - Level change restarts the sample counter
// - Latency at least samples minus one times tick period
`timescale 1ns/1ns
module cigf_filter
	import cigf_pkg::*;
(
	// Clock and reset
	input  wire logic      i_mclk,
	input  wire logic      i_rstn,
	// Configuration
	input  wire cigf_cfg_t i_cfg,
	// Pulse input pin
	input  wire logic      i_pin,
	// Filtered level to accumulator and filter tick
	output logic           o_level,
	output logic           o_tick
);
	logic                  sync_a;
	logic                  sync_b;
	logic                  next_sync_a;
	logic                  next_sync_b;
	logic [CIGF_DIV_W-1:0] div_tgt;
	logic [CIGF_CNT_W-1:0] cnt_tgt;
	logic [CIGF_CNT_W-1:0] cnt_inc;
	logic [CIGF_DIV_W-1:0] div_cnt;
	logic [CIGF_DIV_W-1:0] next_div_cnt;
	logic                  next_tick;
	logic                  samp;
	logic                  next_samp;
	logic [CIGF_CNT_W-1:0] cnt;
	logic [CIGF_CNT_W-1:0] next_cnt;
	logic                  next_level;

	// Treat zero settings as one so the filter never stalls
	function automatic logic [CIGF_DIV_W-1:0] cigf_min1(
		input logic [CIGF_DIV_W-1:0] v);
		cigf_min1 = (v == CIGF_DIV_ZERO) ? CIGF_DIV_ONE : v;
	endfunction : cigf_min1

	// Two-stage pin synchronizer; only the second stage feeds logic
	always_comb begin
		next_sync_a = i_pin;
		next_sync_b = sync_a;
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			sync_a <= CIGF_LVL_RST;
			sync_b <= CIGF_LVL_RST;
		end else begin
			sync_a <= next_sync_a;
			sync_b <= next_sync_b;
		end
	end

	// Filter tick divider
	always_comb begin
		div_tgt      = cigf_min1(i_cfg.div);
		next_div_cnt = div_cnt + CIGF_DIV_ONE;
		next_tick    = 1'b0;
		if (div_cnt >= div_tgt - CIGF_DIV_ONE) begin
			next_div_cnt = CIGF_DIV_ZERO;
			next_tick    = 1'b1;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			div_cnt <= CIGF_DIV_ZERO;
			o_tick  <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			o_tick  <= next_tick;
		end
	end

	// Sample qualifier
	always_comb begin
		cnt_tgt    = cigf_min1(i_cfg.samples);
		cnt_inc    = cnt + CIGF_CNT_ONE;
		next_samp  = samp;
		next_cnt   = cnt;
		next_level = o_level;
		if (!i_cfg.enable) begin
			next_level = sync_b;
			next_samp  = sync_b;
			next_cnt   = CIGF_CNT_ZERO;
		end else if (o_tick) begin
			next_samp = sync_b;
			if (sync_b != samp) begin
				next_cnt = CIGF_CNT_ONE;
				// A one-sample target qualifies on the first sample
				if (cnt_tgt == CIGF_CNT_ONE) begin
					next_cnt   = CIGF_CNT_ZERO;
					next_level = sync_b;
				end
			end else if (cnt_inc >= cnt_tgt) begin
				// only after target ticks of stability
				next_cnt   = CIGF_CNT_ZERO;
				next_level = sync_b;
			end else begin
				next_cnt = cnt_inc;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			samp    <= CIGF_LVL_RST;
			cnt     <= CIGF_CNT_ZERO;
			o_level <= CIGF_LVL_RST;
		end else begin
			samp    <= next_samp;
			cnt     <= next_cnt;
			o_level <= next_level;
		end
	end

	a_fwd_matches: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		i_cfg.enable && $past(i_cfg.enable) && $changed(o_level) |->
		o_level == samp)
		else $error("forwarded level differs from sample");

	a_change_restart: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		i_cfg.enable && o_tick && sync_b != samp &&
		cigf_min1(i_cfg.samples) > CIGF_CNT_ONE |=> cnt == CIGF_CNT_ONE)
		else $error("counter not restarted on change");

	a_cnt_bound: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		i_cfg.enable && o_tick |=>
		!$stable(i_cfg) || cnt < cigf_min1(i_cfg.samples))
		else $error("sample counter past target");

	a_level_hold: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		i_cfg.enable && $past(i_cfg.enable) && !$past(o_tick) |->
		$stable(o_level))
		else $error("level moved without tick");

	a_min_latency: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		i_cfg.enable && $past(i_cfg.enable) && $changed(o_level) |->
		$past(cnt) + CIGF_CNT_ONE >= cigf_min1($past(i_cfg.samples)))
		else $error("level forwarded too early");

	a_bypass: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		!i_cfg.enable |=> o_level == $past(sync_b))
		else $error("bypass level wrong");

	a_bypass_clear: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		!i_cfg.enable |=> cnt == CIGF_CNT_ZERO)
		else $error("counter not cleared in bypass");

	a_sample_tick: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		i_cfg.enable && o_tick |=> samp == $past(sync_b))
		else $error("sample not captured on tick");

	a_sample_hold: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		i_cfg.enable && !o_tick |=> $stable(samp))
		else $error("sample moved without tick");

	a_tick_single: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		i_cfg.div > CIGF_DIV_ONE && $stable(i_cfg.div) && o_tick |=> !o_tick)
		else $error("ticks too close");

	a_tick_every: assert property (
		@(posedge i_mclk) disable iff (!i_rstn)
		$past(i_rstn) && $past(i_cfg.div) <= CIGF_DIV_ONE |-> o_tick)
		else $error("tick missing at divide by one");

	c_forward_high: cover property (@(posedge i_mclk) disable iff (!i_rstn)
		i_cfg.enable && $rose(o_level));
	c_forward_low: cover property (@(posedge i_mclk) disable iff (!i_rstn)
		i_cfg.enable && $fell(o_level));
	c_restart: cover property (@(posedge i_mclk) disable iff (!i_rstn)
		i_cfg.enable && o_tick && sync_b != samp && cnt != CIGF_CNT_ZERO);
	c_bypass_follow: cover property (@(posedge i_mclk) disable iff (!i_rstn)
		!i_cfg.enable && $changed(o_level));
	c_one_sample: cover property (@(posedge i_mclk) disable iff (!i_rstn)
		i_cfg.enable && i_cfg.samples <= CIGF_CNT_ONE && $changed(o_level));
endmodule : cigf_filter

/* verification/cigf_pulse_src.sv */
// Field pulse source that drives the filter input pin
`timescale 1ns/1ns
module cigf_pulse_src (
	// Clock and requested level
	input  wire logic i_clk,
	input  wire logic i_lvl,
	// Pin
	output logic      o_pin
);
	// Pulse rate chosen by the bench
	always @(posedge i_clk) o_pin <= #1 i_lvl;
endmodule : cigf_pulse_src

/* verification/counter_input_glitch_filter_tb.sv */
// Self-checking bench for the glitch filter
`timescale 1ns/1ns
module counter_input_glitch_filter_tb;
	import cigf_pkg::*;
	logic      i_mclk = 0, i_rstn = 0, lvl = 0, prv = 0, o_level, o_tick, pin;
	cigf_cfg_t cfg = '0;
	int        num_errors = 0, tests_run = 0, cyc = 0, seed = 18, lo;
	logic      q[$];
	int        lq[$], dq[$];
	logic [31:0] r;
	cigf_pulse_src i_src (.i_clk(i_mclk), .i_lvl(lvl), .o_pin(pin));
	cigf_filter i_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_cfg(cfg),
		.i_pin(pin), .o_level(o_level), .o_tick(o_tick));
	initial forever #10 i_mclk = ~i_mclk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic complete_run;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : complete_run
	// Toggle the pin; short holds are glitches and come back
	task automatic step(input logic [31:0] x);
		int s, d, h;
		s = cfg.samples == 0 ? 1 : int'(cfg.samples);
		d = cfg.div == 0 ? 1 : int'(cfg.div);
		h = !cfg.enable ? 1 + x[1:0] : (s > 1 && x[9]) ?
			1 + x[15:10] % ((s - 1) * d) : (s + 1) * d + 3 + x[1:0];
		if (!cfg.enable || h > (s - 1) * d) begin
			q.push_back(~lvl);
			lq.push_back(cfg.enable ? cyc + 4 + (s - 1) * d : cyc + 4);
			dq.push_back(cfg.enable ? d : 1);
		end
		lvl = ~lvl;
		repeat (h) @(posedge i_mclk);
		#1;
		if (cfg.enable && h <= (s - 1) * d) begin
			lvl = ~lvl;
			repeat ((s + 2) * d + 4) @(posedge i_mclk);
			#1;
		end
	endtask : step
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc > 60000) begin
			num_errors++;
			complete_run();
		end
	end
	// Each output change must match the oldest note
	always @(negedge i_mclk) if (i_rstn && o_level !== prv) begin
		prv = o_level;
		if (q.size() == 0) check(32'h1, 32'h0);
		else begin
			check(o_level, q.pop_front());
			lo = lq.pop_front();
			check(cyc >= lo && cyc < lo + dq.pop_front(), 1);
		end
	end
	initial begin
		repeat (12) @(posedge i_mclk);
		#1 i_rstn = 1;
		for (int t = 0; t < 90; t++) begin
			r = $random(seed);
			cfg.enable = t >= 10;
			cfg.div = t < 40 ? 16'h0001 : 16'(r[17:16]);
			cfg.samples = 16'(r[22:19] % 6);
			step(r);
			$display("test %0d done", t);
		end
		repeat (20) @(posedge i_mclk);
		check(q.size(), 0);
		complete_run();
	end
endmodule : counter_input_glitch_filter_tb
